//--- pipe_ctrl_pkg.sv
// Shared constants, classes and stage records for the five-stage pipeline control.
package pipe_ctrl_pkg;

  // Instruction classes as produced by the predecoder on the fetch path.
  typedef enum logic [3:0] {
    CLS_ALU      = 4'h0,
    CLS_CUST_CMB = 4'h1,
    CLS_CUST_MC  = 4'h2,
    CLS_BRANCH   = 4'h3,
    CLS_FLUSHER  = 4'h4,
    CLS_JUMP     = 4'h5,
    CLS_RDCTL    = 4'h6,
    CLS_LOAD     = 4'h7,
    CLS_STORE    = 4'h8,
    CLS_MUL      = 4'h9,
    CLS_DIV      = 4'hA,
    CLS_SHIFT    = 4'hB,
    CLS_TRAP     = 4'hC,
    CLS_ILLEGAL  = 4'hD,
    CLS_UNIMPL   = 4'hE,
    CLS_OTHER    = 4'hF
  } iclass_t;

  // Multiplier build options.
  typedef enum logic [1:0] {
    MUL_NONE     = 2'h0,
    MUL_EMBEDDED = 2'h1,
    MUL_LOGIC    = 2'h2
  } mul_kind_t;

  typedef enum logic [2:0] {
    EXC_NONE    = 3'h0,
    EXC_IRQ     = 3'h1,
    EXC_TRAP    = 3'h2,
    EXC_ILLEGAL = 3'h3,
    EXC_UNIMPL  = 3'h4
  } exc_t;

  typedef enum logic [1:0] {
    RDR_NONE      = 2'h0,
    RDR_PREDICTED = 2'h1,
    RDR_FLUSH     = 2'h2
  } redirect_t;

  localparam int CNT_W = 7;

  // Predecoded instruction word as it leaves the fetch stage.
  typedef struct packed {
    iclass_t    cls;
    logic       off_neg;
    logic [4:0] shamt;
    logic [5:0] div_extra;
    logic [7:0] tag;
  } insn_t;

  // One pipeline slot.
  typedef struct packed {
    logic  valid;
    insn_t insn;
    logic  pred_taken;
    exc_t  exc;
  } slot_t;

  localparam slot_t SLOT_EMPTY = '{valid: 1'b0, insn: '0, pred_taken: 1'b0, exc: EXC_NONE};

  localparam int FLUSH_PENALTY   = 3;
  localparam int SHIFT_LAT_EMB   = 3;
  localparam int SHIFT_LAT_LOGIC = 4;
  localparam int MUL_LAT_EMB     = 3;
  localparam int MUL_LAT_LOGIC   = 11;
  localparam int DIV_LAT_MIN     = 4;
  localparam int DIV_LAT_MAX     = 66;

  localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 7'h01;

endpackage

//--- pipe_ctrl.sv
// Five-stage in-order pipeline control: advance, stalls, prediction, flushes, exceptions.
`timescale 1ns/1ps
`default_nettype none

module pipe_ctrl
  import pipe_ctrl_pkg::*;
#(
  parameter pipe_ctrl_pkg::mul_kind_t MUL_KIND = pipe_ctrl_pkg::MUL_EMBEDDED,
  parameter bit                       HAS_DIV  = 1'b1
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // Instruction fetch
  output logic                       fetch_req,
  input  wire logic                  fetch_ack,
  input  wire pipe_ctrl_pkg::insn_t  fetch_insn,
  output logic                       redirect,
  output pipe_ctrl_pkg::redirect_t   redirect_kind,
  // Execution outcome and side units
  input  wire logic                  br_taken,
  input  wire logic                  cust_stall,
  input  wire logic                  irq,
  // Data bus
  output logic                       dbus_read,
  output logic                       dbus_write,
  input  wire logic                  dbus_waitrequest,
  input  wire logic                  dbus_readdatavalid,
  // Status
  output logic [4:0]                 stage_valid,
  output logic                       stall,
  output logic                       dispatch,
  output logic [7:0]                 dispatch_tag,
  output logic                       retire,
  output pipe_ctrl_pkg::slot_t       retire_slot
);
  import pipe_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Stage registers and the memory stage stall.

  slot_t f_slot;
  slot_t d_slot;
  slot_t e_slot;
  slot_t m_slot;
  slot_t w_slot;

  logic [CNT_W-1:0] occ_cnt;
  logic             dbus_accepted;
  logic             m_is_load;
  logic             m_is_store;
  logic             mem_done;
  logic             mem_stall;
  logic             unit_stall;
  logic             fetch_wait;
  logic             advance;
  logic             m_flush;
  logic             m_mispredict;
  logic             d_predict;
  exc_t             m_exc;
  logic [CNT_W-1:0] next_occ;

  assign m_is_load  = m_slot.valid && (m_slot.insn.cls == CLS_LOAD);
  assign m_is_store = m_slot.valid && (m_slot.insn.cls == CLS_STORE);

  // Requests drop once the slave has taken them, so each access is issued once.
  assign dbus_read  = m_is_load && !dbus_accepted;
  assign dbus_write = m_is_store && !dbus_accepted;

  always_comb begin
    mem_done = 1'b1;
    if (m_is_store) begin
      mem_done = dbus_accepted || !dbus_waitrequest;
    end else if (m_is_load) begin
      mem_done = dbus_readdatavalid && (dbus_accepted || !dbus_waitrequest);
    end
  end

  assign mem_stall  = (m_is_load || m_is_store) && !mem_done;
  assign unit_stall = (occ_cnt != CNT_ZERO)
                   || (m_slot.valid && (m_slot.insn.cls == CLS_CUST_MC) && cust_stall);

  // A fetch still in flight is folded into the same single stall term.
  assign fetch_req  = 1'b1;
  assign fetch_wait = fetch_req && !fetch_ack;

  // One global hold keeps every stage from closing bubbles while stalled.
  assign stall   = mem_stall || unit_stall || fetch_wait;
  assign advance = !stall;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dbus_accepted <= 1'b0;
    end else if (advance) begin
      dbus_accepted <= 1'b0;
    end else if ((dbus_read || dbus_write) && !dbus_waitrequest) begin
      dbus_accepted <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multi-cycle unit occupancy, loaded when an instruction enters memory.

  function automatic logic [CNT_W-1:0] unit_latency(input insn_t insn);
    logic [CNT_W-1:0] lat;
    lat = CNT_ONE;
    unique case (insn.cls)
      CLS_SHIFT: begin
        if (MUL_KIND == MUL_EMBEDDED) begin
          lat = CNT_W'(SHIFT_LAT_EMB);
        end else if (MUL_KIND == MUL_LOGIC) begin
          lat = CNT_W'(SHIFT_LAT_LOGIC);
        end else begin
          lat = CNT_W'({2'b00, insn.shamt}) + CNT_ONE;
        end
      end
      CLS_MUL: begin
        if (MUL_KIND == MUL_EMBEDDED) begin
          lat = CNT_W'(MUL_LAT_EMB);
        end else if (MUL_KIND == MUL_LOGIC) begin
          lat = CNT_W'(MUL_LAT_LOGIC);
        end
      end
      CLS_DIV: begin
        if (HAS_DIV) begin
          lat = CNT_W'(DIV_LAT_MIN) + CNT_W'(insn.div_extra);
          if (lat > CNT_W'(DIV_LAT_MAX)) begin
            lat = CNT_W'(DIV_LAT_MAX);
          end
        end
      end
      default: begin
        lat = CNT_ONE;
      end
    endcase
    return lat;
  endfunction

  always_comb begin
    next_occ = occ_cnt;
    if (occ_cnt != CNT_ZERO) begin
      next_occ = occ_cnt - CNT_ONE;
    end else if (advance && e_slot.valid && !m_flush) begin
      next_occ = unit_latency(e_slot.insn) - CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      occ_cnt <= CNT_ZERO;
    end else begin
      occ_cnt <= next_occ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Resolution in the memory stage: flushes and exceptions.

  always_comb begin
    m_exc = EXC_NONE;
    if (m_slot.valid) begin
      unique case (m_slot.insn.cls)
        CLS_TRAP:    m_exc = EXC_TRAP;
        CLS_ILLEGAL: m_exc = EXC_ILLEGAL;
        CLS_UNIMPL:  m_exc = EXC_UNIMPL;
        CLS_MUL:     m_exc = (MUL_KIND == MUL_NONE) ? EXC_UNIMPL : EXC_NONE;
        CLS_DIV:     m_exc = HAS_DIV ? EXC_NONE : EXC_UNIMPL;
        default:     m_exc = EXC_NONE;
      endcase
      if ((m_exc == EXC_NONE) && irq) begin
        m_exc = EXC_IRQ;
      end
    end
  end

  assign m_mispredict = m_slot.valid && (m_slot.insn.cls == CLS_BRANCH)
                     && (br_taken != m_slot.pred_taken);

  // Flushing in memory cancels the three younger slots in fetch, decode and execute.
  assign m_flush = advance && m_slot.valid
                && (m_mispredict
                 || (m_slot.insn.cls == CLS_FLUSHER)
                 || (m_slot.insn.cls == CLS_JUMP)
                 || (m_exc != EXC_NONE));

  // Backward branch in decode redirects fetch, dropping one younger slot.
  assign d_predict = advance && d_slot.valid && (d_slot.insn.cls == CLS_BRANCH)
                  && d_slot.insn.off_neg;

  assign redirect = m_flush || d_predict;

  always_comb begin
    redirect_kind = RDR_NONE;
    if (m_flush) begin
      redirect_kind = RDR_FLUSH;
    end else if (d_predict) begin
      redirect_kind = RDR_PREDICTED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage advance, one concern per register.

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      f_slot <= SLOT_EMPTY;
    end else if (advance) begin
      // The word returned in a redirect cycle is the new target, so a flush loses only F, D and E, and a prediction only F.
      f_slot <= '{valid: 1'b1, insn: fetch_insn, pred_taken: 1'b0, exc: EXC_NONE};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      d_slot <= SLOT_EMPTY;
    end else if (advance) begin
      if (m_flush || d_predict) begin
        d_slot <= m_flush ? SLOT_EMPTY : f_slot;
      end else begin
        d_slot <= f_slot;
      end
      if (d_predict && !m_flush) begin
        d_slot <= SLOT_EMPTY;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      e_slot <= SLOT_EMPTY;
    end else if (advance) begin
      if (m_flush) begin
        e_slot <= SLOT_EMPTY;
      end else begin
        e_slot            <= d_slot;
        e_slot.pred_taken <= d_predict;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      m_slot <= SLOT_EMPTY;
    end else if (advance) begin
      m_slot <= m_flush ? SLOT_EMPTY : e_slot;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      w_slot <= SLOT_EMPTY;
    end else if (advance) begin
      w_slot     <= m_slot;
      w_slot.exc <= m_exc;
    end else begin
      w_slot <= SLOT_EMPTY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs.

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dispatch     <= 1'b0;
      dispatch_tag <= 8'h00;
    end else begin
      dispatch     <= advance && d_slot.valid && !m_flush;
      dispatch_tag <= d_slot.insn.tag;
    end
  end

  assign stage_valid = {w_slot.valid, m_slot.valid, e_slot.valid, d_slot.valid, f_slot.valid};
  assign retire      = w_slot.valid;
  assign retire_slot = w_slot;

endmodule

`default_nettype wire

//--- pipe_ctrl_monitor.sv
// Concurrent checks on the pipeline control ports.
`timescale 1ns/1ps
`default_nettype none
module pipe_ctrl_monitor
  import pipe_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic                     clk_sys,
  input wire logic                     rst_n,
  // Watched ports
  input wire logic                     fetch_ack,
  input wire logic                     redirect,
  input wire pipe_ctrl_pkg::redirect_t redirect_kind,
  input wire logic                     dbus_read,
  input wire logic                     dbus_write,
  input wire logic                     dbus_waitrequest,
  input wire logic [4:0]               stage_valid,
  input wire logic                     stall,
  input wire logic                     retire
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_flush;
    redirect && redirect_kind == RDR_FLUSH;
  endsequence
  sequence s_pred;
    redirect && redirect_kind == RDR_PREDICTED;
  endsequence
  sequence s_bus_wait;
    (dbus_read || dbus_write) && dbus_waitrequest;
  endsequence
  AST_HOLD: assert property (stall |=> stage_valid[3:0] == $past(stage_valid[3:0]))
    else $error("stalled stages changed");
  AST_W_EMPTY: assert property (stall |=> !retire)
    else $error("retire during stall");
  AST_FETCH_WAIT: assert property (!fetch_ack |-> stall)
    else $error("no hold while fetch waits");
  AST_ONLY_M: assert property (fetch_ack && !stage_valid[3] |-> !stall)
    else $error("stall without memory stage");
  AST_BUS_HOLD: assert property (s_bus_wait |=> $stable({dbus_read, dbus_write}))
    else $error("bus request dropped early");
  AST_BUS_STALL: assert property (s_bus_wait |-> stall)
    else $error("no stall on bus wait");
  AST_FLUSH: assert property (s_flush |=> stage_valid[3:1] == 3'b000)
    else $error("younger slots survive flush");
  AST_PRED: assert property (s_pred |=> stage_valid[2:1] == 2'b10)
    else $error("predicted redirect kept slot");
  AST_ADVANCE: assert property (!stall && stage_valid[3] |=> retire)
    else $error("memory stage did not retire");
endmodule
bind pipe_ctrl pipe_ctrl_monitor u_pipe_ctrl_monitor (.clk_sys, .rst_n, .fetch_ack, .redirect,
  .redirect_kind, .dbus_read, .dbus_write, .dbus_waitrequest, .stage_valid, .stall, .retire);
`default_nettype wire

//--- dbus_model.sv
// Data bus slave model with prompt or slow answers.
`timescale 1ns/1ps
`default_nettype none
module dbus_model (
  // Clock and reset
  input wire logic  clk_sys,
  input wire logic  rst_n,
  // Mode and bus
  input wire logic  slow,
  input wire logic  dbus_read,
  input wire logic  dbus_write,
  output logic      dbus_waitrequest,
  output logic      dbus_readdatavalid
);
  int wcnt;
  int rcnt;
  int sd = 92;
  // The wait count is reloaded while idle, so a request that follows an idle cycle sees a fresh delay.
  assign dbus_waitrequest = (dbus_read || dbus_write) && wcnt != 0;
  assign dbus_readdatavalid = rcnt == 1;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !(dbus_read || dbus_write)) begin
      wcnt <= slow ? ($random(sd) & 3) : 0;
    end else if (wcnt != 0) begin
      wcnt <= wcnt - 1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rcnt <= 0;
    end else if (dbus_read && !dbus_waitrequest) begin
      rcnt <= slow ? 3 : 1;
    end else if (rcnt != 0) begin
      rcnt <= rcnt - 1;
    end
  end
endmodule
`default_nettype wire

//--- test_five_stage_pipeline_control.sv
// Self-checking bench for the five-stage pipeline control.
`timescale 1ns/1ps
`default_nettype none
module test_five_stage_pipeline_control;
  import pipe_ctrl_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       fetch_ack = 1'b0;
  logic       br_taken = 1'b0;
  logic       cust_stall = 1'b0;
  logic       irq = 1'b0;
  logic       slow = 1'b0;
  insn_t      fetch_insn = '0;
  logic       fetch_req, redirect, dbus_read, dbus_write, dbus_waitrequest;
  logic       dbus_readdatavalid, stall, dispatch, retire;
  logic [7:0] dispatch_tag;
  logic [4:0] stage_valid;
  redirect_t  redirect_kind;
  slot_t      retire_slot;
  insn_t      exp[$];
  bit         pq[$];
  insn_t      w;
  exc_t       ex;
  int         seed = 92, bad_count = 0, compares = 0, last = 0, gap = -1, i, xt;
  bit         tk = 0, br_p = 0, irq_p = 0, ph2 = 0;
  always #20 clk_sys = ~clk_sys;
  pipe_ctrl u_pipe_ctrl (.clk_sys, .rst_n, .fetch_req, .fetch_ack, .fetch_insn, .redirect,
    .redirect_kind, .br_taken, .cust_stall, .irq, .dbus_read, .dbus_write, .dbus_waitrequest,
    .dbus_readdatavalid, .stage_valid, .stall, .dispatch, .dispatch_tag, .retire, .retire_slot);
  dbus_model u_dbus_model (.clk_sys, .rst_n, .slow, .dbus_read, .dbus_write, .dbus_waitrequest,
    .dbus_readdatavalid);
  ////////////////////////////////////////////////////////////////////////////
  task check(input bit ok, input string m);
    compares++;
    if (!ok) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task final_report;
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Outputs are read 5 ns after the falling edge, when they show what the next edge samples.
  initial begin
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int k = 0; k < 6000; k++) begin
      @(negedge clk_sys);
      ph2 = k >= 3000;
      slow = ph2;
      if (tk) fetch_insn = insn_t'(24'($random(seed)));
      tk = 0;
      fetch_ack = k > 0 && (!ph2 || ($random(seed) & 3) != 0);
      br_taken = 1'($random(seed));
      cust_stall = 1'($random(seed));
      irq = ph2 && (k % 400) < 8;
      #5;
      check(fetch_req === 1'b1, "fetch request dropped");
      if (retire === 1'b1) begin
        check(exp.size() > 0, "retire with nothing pending");
        w = exp.size() > 0 ? exp.pop_front() : '0;
        if (pq.size() > 0) void'(pq.pop_front());
        check(retire_slot.insn === w, "retire order");
        ex = w.cls == CLS_TRAP ? EXC_TRAP : w.cls == CLS_ILLEGAL ? EXC_ILLEGAL :
             w.cls == CLS_UNIMPL ? EXC_UNIMPL : irq_p ? EXC_IRQ : EXC_NONE;
        check(retire_slot.exc === ex, "exception code");
        // Multi-cycle work delays its own retirement; flush penalties delay the next one.
        case (w.cls)
          CLS_SHIFT, CLS_MUL: xt = 2;
          CLS_DIV: xt = (w.div_extra > 6'h3E) ? 65 : 3 + w.div_extra;
          CLS_LOAD, CLS_STORE, CLS_CUST_MC: xt = -1;
          default: xt = 0;
        endcase
        if (!ph2 && gap > 0 && xt >= 0) check(k - last == gap + xt, "retire spacing");
        last = k;
        case (w.cls)
          CLS_BRANCH: gap = (br_p != w.off_neg) ? 4 : (w.off_neg ? 2 : 1);
          CLS_FLUSHER, CLS_JUMP, CLS_TRAP, CLS_ILLEGAL, CLS_UNIMPL: gap = 4;
          default: gap = 1;
        endcase
      end
      if (dispatch === 1'b1) check(exp.size() > int'(stage_valid[3]) && exp[stage_valid[3]].tag === dispatch_tag, "dispatch tag");
      // Younger work is cut from the expected queue only when the pipe announces it.
      if (redirect === 1'b1 && redirect_kind == RDR_FLUSH) begin
        while (exp.size() > 1) begin
          void'(exp.pop_back());
          void'(pq.pop_back());
        end
      end else if (redirect === 1'b1 && redirect_kind == RDR_PREDICTED) begin
        for (i = 0; i < exp.size(); i++) if (exp[i].cls == CLS_BRANCH && exp[i].off_neg && !pq[i]) break;
        check(i < exp.size(), "prediction without backward branch");
        if (i < exp.size()) pq[i] = 1;
        while (exp.size() > i + 1) begin
          void'(exp.pop_back());
          void'(pq.pop_back());
        end
      end
      if (fetch_ack && stall === 1'b0) begin
        exp.push_back(fetch_insn);
        pq.push_back(0);
        tk = 1;
      end
      br_p = br_taken;
      irq_p = irq;
    end
    final_report();
  end
  // The run needs about 6000 cycles of 40 ns; the limit lies about a quarter above that.
  initial begin
    #300000;
    bad_count++;
    final_report();
  end
endmodule
`default_nettype wire
